//--- bcpm_pkg.sv
// Constants, register map and carrier types of the bus control pin mux.
// Assumes one 200 MHz clock and a plain register port with 32-bit addresses.
package bcpm_pkg;

  localparam int NPORT = 4;
  localparam int NKIND = 4;
  localparam int DW = 8;
  localparam int AW = 32;

  // Port indices.
  localparam int P_HS = 0;
  localparam int P_CS = 1;
  localparam int P_ST = 2;
  localparam int P_HA = 3;

  // Register kinds.
  localparam int K_DATA = 0;
  localparam int K_DIR = 1;
  localparam int K_FSEL = 2;
  localparam int K_PULL = 3;

  // Register addresses, indexed by kind then port.
  localparam logic [AW-1:0] REG_ADDR [NKIND][NPORT] = '{
    '{32'hFFFFF100, 32'hFFFFF101, 32'hFFFFF102, 32'hFFFFF103},
    '{32'hFFFFF110, 32'hFFFFF111, 32'hFFFFF112, 32'hFFFFF113},
    '{32'hFFFFF04C, 32'hFFFFF120, 32'hFFFFF04A, 32'hFFFFF121},
    '{32'hFFFFF130, 32'hFFFFF131, 32'hFFFFF132, 32'hFFFFF133}};

  // Pins present, implemented function bits and alternate output pins.
  localparam logic [DW-1:0] PIN_MASK [NPORT] =
    '{8'h3F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [DW-1:0] FSEL_MASK [NPORT] =
    '{8'h0F, 8'h0F, 8'h53, 8'hFF};
  localparam logic [DW-1:0] ALT_OUT_MASK [NPORT] =
    '{8'h06, 8'h0F, 8'h53, 8'hFF};

  // Bit positions of the alternate functions.
  localparam int HS_BIT_STALL = 0;
  localparam int HS_BIT_CLOCK = 1;
  localparam int HS_BIT_HOLD_ACK = 2;
  localparam int HS_BIT_HOLD_REQ = 3;
  localparam int ST_BIT_WRITE0 = 0;
  localparam int ST_BIT_WRITE1 = 1;
  localparam int ST_BIT_READ = 4;
  localparam int ST_BIT_ADDR_LATCH = 6;

  // Reset values.
  localparam logic [DW-1:0] DATA_RST = 8'h00;
  localparam logic [DW-1:0] DIR_RST = 8'hFF;
  localparam logic [DW-1:0] FSEL_RST = 8'h00;
  localparam logic [DW-1:0] PULL_RST = 8'h00;

  typedef struct packed {
    logic [DW-1:0] dout;
    logic [DW-1:0] oe_n;
    logic [DW-1:0] pull_en;
  } bcpm_pad_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } bcpm_req_t;

  typedef struct packed {
    logic [3:0] chip_select_n;
    logic write_strobe_0_n;
    logic write_strobe_1_n;
    logic read_strobe_n;
    logic address_latch_strobe;
    logic clock_output_pin;
    logic bus_hold_acknowledge_n;
    logic [7:0] address_hi;
  } bcpm_alt_t;

endpackage : bcpm_pkg

//--- bcpm_pin_mux.sv
// Pin multiplexer and general-purpose I/O of the bus control ports.
// Assumes pins are sampled synchronously and alternates come from the
// external bus controller in the same clock domain.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module bcpm_pin_mux
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port.
  input wire bcpm_pkg::bcpm_req_t req,
  output logic [bcpm_pkg::DW-1:0] rdata,
  // Alternate functions of the bus controller.
  input wire bcpm_pkg::bcpm_alt_t alt,
  output logic bus_stall_n,
  output logic bus_hold_request_n,
  // Buffer shut-off causes.
  input wire logic low_power,
  input wire logic bus_held,
  // Pins.
  input wire logic [bcpm_pkg::NPORT-1:0][bcpm_pkg::DW-1:0] pin_in,
  output bcpm_pkg::bcpm_pad_t [bcpm_pkg::NPORT-1:0] pad
);
  import bcpm_pkg::*;

  logic [NPORT-1:0][DW-1:0] data_v;
  logic [NPORT-1:0][DW-1:0] dir_v;
  logic [NPORT-1:0][DW-1:0] fsel_v;
  logic [NPORT-1:0][DW-1:0] pull_v;
  logic [NPORT-1:0][DW-1:0] rd_v;
  logic [NPORT-1:0][DW-1:0] alt_val;
  logic hit;
  logic [1:0] hit_kind;
  logic [1:0] hit_port;
  logic buf_off;
  logic [DW-1:0] rdata_d;

  assign buf_off = low_power | bus_held;

  // Address decode.
  always_comb
  begin
    hit = 1'b0;
    hit_kind = 2'h0;
    hit_port = 2'h0;
    for (int k = 0; k < NKIND; k++)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (req.addr == REG_ADDR[k][p])
        begin
          hit = 1'b1;
          hit_kind = 2'(k);
          hit_port = 2'(p);
        end
      end
    end
  end

  // Alternate output values placed on their pin positions.
  always_comb
  begin
    alt_val = '0;
    alt_val[P_HS][HS_BIT_CLOCK] = alt.clock_output_pin;
    alt_val[P_HS][HS_BIT_HOLD_ACK] = alt.bus_hold_acknowledge_n;
    alt_val[P_CS][3:0] = alt.chip_select_n;
    alt_val[P_ST][ST_BIT_WRITE0] = alt.write_strobe_0_n;
    alt_val[P_ST][ST_BIT_WRITE1] = alt.write_strobe_1_n;
    alt_val[P_ST][ST_BIT_READ] = alt.read_strobe_n;
    alt_val[P_ST][ST_BIT_ADDR_LATCH] = alt.address_latch_strobe;
    alt_val[P_HA] = alt.address_hi;
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic [DW-1:0] data_q;
    logic [DW-1:0] dir_q;
    logic [DW-1:0] fsel_q;
    logic [DW-1:0] pull_q;
    logic sel;
    logic [DW-1:0] drive_alt;
    logic [DW-1:0] drive;

    assign sel = req.wr && hit && (hit_port == 2'(p));

    // Port registers; unimplemented bits never store a one.
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        data_q <= DATA_RST;
        dir_q <= DIR_RST & PIN_MASK[p];
        fsel_q <= FSEL_RST;
        pull_q <= PULL_RST;
      end
      else if (ce && sel)
      begin
        case (hit_kind)
          2'(K_DATA): data_q <= req.wdata & PIN_MASK[p];
          2'(K_DIR): dir_q <= req.wdata & PIN_MASK[p];
          2'(K_FSEL): fsel_q <= req.wdata & FSEL_MASK[p];
          2'(K_PULL): pull_q <= req.wdata & PIN_MASK[p];
          default: data_q <= data_q;
        endcase
      end
    end

    // Alternate outputs override direction; alternate inputs never drive.
    assign drive_alt = fsel_q & ALT_OUT_MASK[p];
    assign drive = buf_off ? '0 :
      (drive_alt | (~fsel_q & ~dir_q & PIN_MASK[p]));

    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        pad[p].dout <= '0;
        pad[p].oe_n <= '1;
        pad[p].pull_en <= '0;
      end
      else if (ce)
      begin
        pad[p].dout <= (drive_alt & alt_val[p]) | (~fsel_q & data_q);
        pad[p].oe_n <= ~drive;
        pad[p].pull_en <= pull_q;
      end
    end

    assign data_v[p] = data_q;
    assign dir_v[p] = dir_q;
    assign fsel_v[p] = fsel_q;
    assign pull_v[p] = pull_q;
    assign rd_v[p] = ((dir_q & pin_in[p]) | (~dir_q & data_q))
      & PIN_MASK[p];
  end

  // Read data appear in the cycle after a strobe taken with ce set, and stay until the next cycle with ce set.
  always_comb
  begin
    rdata_d = '0;
    if (req.rd && hit)
    begin
      case (hit_kind)
        2'(K_DATA): rdata_d = rd_v[hit_port];
        2'(K_DIR): rdata_d = dir_v[hit_port];
        2'(K_FSEL): rdata_d = fsel_v[hit_port];
        2'(K_PULL): rdata_d = pull_v[hit_port];
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata <= '0;
    end
    else if (ce)
    begin
      rdata <= rdata_d;
    end
  end

  // Alternate inputs handed to the bus controller, idle high when not selected.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_stall_n <= 1'b1;
      bus_hold_request_n <= 1'b1;
    end
    else if (ce)
    begin
      bus_stall_n <= fsel_v[P_HS][HS_BIT_STALL] ?
        pin_in[P_HS][HS_BIT_STALL] : 1'b1;
      bus_hold_request_n <= fsel_v[P_HS][HS_BIT_HOLD_REQ] ?
        pin_in[P_HS][HS_BIT_HOLD_REQ] : 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_HS_SIX_PINS: assert property (pad[P_HS].oe_n[7:6] == 2'b11)
    else $error("Absent handshake pins are driven.");

  AST_CS_ALT: assert property (ce && !buf_off && fsel_v[P_CS][0]
    |=> !pad[P_CS].oe_n[0] && pad[P_CS].dout[0] == $past(alt.chip_select_n[0]))
    else $error("Chip select 0 not driven in alternate mode.");

  AST_ST_FSEL_BITS: assert property (ce && req.wr && hit
    && hit_kind == 2'(K_FSEL) && hit_port == 2'(P_ST)
    |=> fsel_v[P_ST] == ($past(req.wdata) & 8'h53))
    else $error("Strobe function select stores wrong bits.");

  AST_HA_ALT: assert property (ce && !buf_off && fsel_v[P_HA][7]
    |=> !pad[P_HA].oe_n[7] && pad[P_HA].dout[7] == $past(alt.address_hi[7]))
    else $error("Address bit 23 not driven in alternate mode.");

  AST_HS_FSEL_RESET: assert property ($fell(sys_rst)
    |-> fsel_v[P_HS] == 8'h00 && dir_v[P_HS] == 8'h3F)
    else $error("Handshake registers wrong after reset.");

  AST_HS_ALT_INPUT: assert property (ce && fsel_v[P_HS][HS_BIT_HOLD_REQ]
    |=> pad[P_HS].oe_n[HS_BIT_HOLD_REQ] ##0
    bus_hold_request_n == $past(pin_in[P_HS][HS_BIT_HOLD_REQ]))
    else $error("Hold request pin not an input in alternate mode.");

  AST_PULL: assert property (ce |=> pad[P_CS].pull_en == $past(pull_v[P_CS]))
    else $error("Pull-up enable does not follow its register.");

  AST_BUF_OFF: assert property (ce && buf_off ##1 ce && buf_off
    |=> pad[P_ST].oe_n == 8'hFF && pad[P_HA].oe_n == 8'hFF)
    else $error("Buffers driven while shut off.");

  AST_GPIO_OUT: assert property (ce && !buf_off && !fsel_v[P_ST][2]
    && !dir_v[P_ST][2] |=> !pad[P_ST].oe_n[2]
    && pad[P_ST].dout[2] == $past(data_v[P_ST][2]))
    else $error("Output pin does not drive its latch.");

  AST_READ: assert property (ce && req.rd && hit && hit_kind == 2'(K_DATA)
    |=> rdata == $past(rd_v[hit_port]))
    else $error("Data read returns wrong value.");

  COV_HOLD: cover property (bus_held ##1 !bus_held);
  COV_CS_ALT: cover property (fsel_v[P_CS][3] && !pad[P_CS].oe_n[3]);
  COV_READ: cover property (req.rd && hit ##1 rdata != 8'h00);

endmodule : bcpm_pin_mux

//--- bcpm_ext_model.sv
// Model of the memories and peripherals on the bus control pins.
// Assumes the pad carrier of the pin mux and the same clock.
`timescale 1ns/1ps
module bcpm_ext_model
  import bcpm_pkg::*;
(
  // Clock and pads.
  input wire logic clk,
  input wire bcpm_pad_t [NPORT-1:0] pad,
  // Values that the far side drives.
  input wire logic ext_en,
  input wire logic [NPORT-1:0][DW-1:0] ext,
  // Pin levels.
  output logic [NPORT-1:0][DW-1:0] pin_in
);
  logic [DW-1:0] tog_q = 8'h55;
  always_ff @(posedge clk)
  begin
    tog_q <= ~tog_q;
  end
  // A released line takes the far-side value when ext_en is set, else rises with its pull-up or wanders.
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      pin_in[p] = (~pad[p].oe_n & pad[p].dout) | (pad[p].oe_n &
        (ext_en ? ext[p] : (pad[p].pull_en | tog_q)));
    end
  end
endmodule : bcpm_ext_model

//--- test_bcpm_pin_mux.sv
// Self-checking bench of the bus control pin mux.
// Assumes the external model drives the pins back to the mux.
`timescale 1ns/1ps
module test_bcpm_pin_mux;
  import bcpm_pkg::*;
  logic clk = 0, sys_rst = 1, ce = 1, low_power = 0, bus_held = 0;
  logic ext_en = 1;
  bcpm_req_t req = '0;
  bcpm_alt_t alt = '0;
  logic [NPORT-1:0][DW-1:0] ext = '0, pin_in;
  logic [DW-1:0] rdata, rv;
  logic [31:0] r;
  logic bus_stall_n, bus_hold_request_n;
  bcpm_pad_t [NPORT-1:0] pad;
  logic [DW-1:0] rg [NKIND][NPORT];
  int n_mismatch = 0, checked = 0, seed = 32'hA135, k, p;
  bcpm_pin_mux i_bcpm_pin_mux (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .req(req), .rdata(rdata), .alt(alt), .bus_stall_n(bus_stall_n),
    .bus_hold_request_n(bus_hold_request_n), .low_power(low_power),
    .bus_held(bus_held), .pin_in(pin_in), .pad(pad));
  bcpm_ext_model i_bcpm_ext_model (.clk(clk), .pad(pad),
    .ext_en(ext_en), .ext(ext), .pin_in(pin_in));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [DW-1:0] altv(int p);
    case (p)
      P_HS: return {5'h0, alt.bus_hold_acknowledge_n,
        alt.clock_output_pin, 1'h0};
      P_CS: return {4'h0, alt.chip_select_n};
      P_ST: return {1'h0, alt.address_latch_strobe, 1'h0,
        alt.read_strobe_n, 2'h0, alt.write_strobe_1_n, alt.write_strobe_0_n};
      default: return alt.address_hi;
    endcase
  endfunction : altv
  function automatic logic [DW-1:0] exp_rd(int k, int p);
    if (k != K_DATA)
      return rg[k][p];
    return PIN_MASK[p] & ((rg[K_DIR][p] & pin_in[p]) |
      (~rg[K_DIR][p] & rg[K_DATA][p]));
  endfunction : exp_rd
  task automatic chk(string nm, logic [DW-1:0] e, logic [DW-1:0] g);
    checked++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic setr(int k, int p, logic [DW-1:0] d);
    @(posedge clk);
    req <= '{REG_ADDR[k][p], d, 1'h1, 1'h0};
    @(posedge clk);
    req.wr <= 1'h0;
    rg[k][p] = d & (k == K_FSEL ? FSEL_MASK[p] : PIN_MASK[p]);
  endtask : setr
  task automatic rd(logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk);
    req.rd <= 1'h0;
    #1 d = rdata;
  endtask : rd
  task automatic rdchk(int k, int p);
    rd(REG_ADDR[k][p], rv);
    chk("read", exp_rd(k, p), rv & (k == K_FSEL ? 8'hFF : PIN_MASK[p]));
  endtask : rdchk
  task automatic chk_pads();
    logic [DW-1:0] d, f;
    repeat (2) @(posedge clk);
    #1;
    for (int p = 0; p < NPORT; p++)
    begin
      f = rg[K_FSEL][p];
      d = PIN_MASK[p] & ((f & ALT_OUT_MASK[p]) | (~f & ~rg[K_DIR][p]));
      chk("oe_n", PIN_MASK[p] & (low_power | bus_held ? 8'hFF : ~d),
        PIN_MASK[p] & pad[p].oe_n);
      chk("dout", d & ((f & altv(p)) | (~f & rg[K_DATA][p])),
        d & pad[p].dout);
      chk("pull_en", rg[K_PULL][p], PIN_MASK[p] & pad[p].pull_en);
    end
    f = ~rg[K_FSEL][P_HS] | ext[P_HS];
    if (ext_en)
      chk("hs_in", f & 8'h09, {4'h0, bus_hold_request_n, 2'h0,
        bus_stall_n});
  endtask : chk_pads
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    for (k = 0; k < NKIND; k++)
      for (p = 0; p < NPORT; p++)
        rg[k][p] = k == K_DIR ? PIN_MASK[p] : 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    chk_pads();
    for (k = 0; k < NKIND; k++)
      for (p = 0; p < NPORT; p++)
        rdchk(k, p);
    rd(32'hFFFFF0FF, rv);
    chk("unmapped", 8'h00, rv);
    $display("reset test done");
    for (p = 0; p < NPORT; p++)
      setr(K_FSEL, p, 8'hFF);
    chk_pads();
    low_power <= 1'h1;
    chk_pads();
    $display("alternate test done");
    repeat (400)
    begin
      @(posedge clk);
      k = $unsigned($random(seed)) % NKIND;
      p = $unsigned($random(seed)) % NPORT;
      r = $random(seed);
      ext <= {$random(seed)};
      alt <= r[$bits(alt)-1:0];
      low_power <= r[31:29] == 3'h0;
      bus_held <= r[28:26] == 3'h0;
      ext_en <= k == K_DATA || r[25];
      setr(k, p, r[DW-1:0]);
      chk_pads();
      rdchk(k, p);
    end
    $display("random test done");
    end_of_test();
  end
endmodule : test_bcpm_pin_mux
